// ==== fan_monitor_config_status_regs_test.sv ====
// Self-checking bench for the fan monitor register group.
`define CHK(nm, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("wrong value %s exp %h got %h", nm, e, g); \
  end \
end
module fan_monitor_config_status_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  fmc_pkg::fmc_bus_s bus;
  logic [7:0] rdata, duty1, duty2, duty3, e, sec = 8'h00;
  fmc_pkg::fmc_cfg_s cfg;
  logic irq, rd_d = 1'b0, mode = 1'b0, tmr = 1'b0, ce = 1'b1;
  logic [6:0] cond = 7'h00;
  logic [7:0] exp_q[$];
  logic [15:0] seed = 16'h6CAE;
  int err_count = 0;
  int total_checks = 0;
  always #2.5 clk_in = ~clk_in;
  fmc_host_model host_u (.bus_out(bus), .clk_in(clk_in));
  fmc_regs dut_u (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce),
    .bus_in(bus), .rdata_out(rdata), .volt_cond_in(cond[2:0]),
    .volt5_cond_in(cond[3]), .thermal_limit_pin_timer_in(tmr),
    .thermal_limit_pin_pin_mode_in(mode), .temp_cond_in(cond[6:4]),
    .second_status_in(sec), .duty1_out(duty1), .duty2_out(duty2),
    .duty3_out(duty3), .cfg_out(cfg), .irq_out(irq));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.access(a, d, 1'b1);
  endtask
  // The expectation is queued before the strobe so the monitor finds it.
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    host_u.access(a, 8'h00, 1'b0);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Read data stand only in the cycle after the strobe; compare there.
  always @(posedge clk_in) begin
    if (rd_d) begin
      e = exp_q.pop_front();
      `CHK("rdata", e, rdata)
    end
    rd_d <= bus.rd;
  end
  // A hang ends the run with a mismatch counted.
  initial begin
    #100000;
    err_count++;
    close_out();
  end
  initial begin
    logic [7:0] v [3];
    cyc(4);
    rst_in <= 1'b0;
    rd(fmc_pkg::CFG_OFS, 8'h01);
    for (int i = 0; i < 3; i++) rd(8'h38 + 8'(i), 8'hFF);
    cyc(fmc_pkg::PWRUP_CYC);
    rd(fmc_pkg::CFG_OFS, 8'h05);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      v[i] = seed[7:0];
      wr(8'h38 + 8'(i), v[i]);
    end
    cyc(2);
    `CHK("duty1", v[0], duty1)
    `CHK("duty2", v[1], duty2)
    `CHK("duty3", v[2], duty3)
    for (int i = 0; i < 3; i++) rd(8'h38 + 8'(i), v[i]);
    wr(fmc_pkg::CFG_OFS, 8'hF8);
    cyc(2);
    `CHK("cfg", 8'hFC, cfg)
    wr(fmc_pkg::CFG_OFS, 8'h01);
    rd(fmc_pkg::CFG_OFS, 8'h05);
    // A write while the clock enable is low must leave no trace.
    ce <= 1'b0;
    wr(fmc_pkg::DUTY2_OFS, ~v[1]);
    ce <= 1'b1;
    rd(fmc_pkg::DUTY2_OFS, v[1]);
    $display("test config done");
    // Each of the seven cond bits alone: set, reported and cleared by the first read, zero at the second.
    for (int i = 0; i < 7; i++) begin
      cyc(1);
      cond <= 7'h01 << i;
      cyc(3);
      cond <= 7'h00;
      cyc(2);
      rd(fmc_pkg::STAT1_OFS, 8'h01 << i);
      cyc(2);
      rd(fmc_pkg::STAT1_OFS, 8'h00);
    end
    cyc(1);
    mode <= 1'b1;
    cond <= 7'h09;
    sec <= 8'h20;
    cyc(3);
    rd(fmc_pkg::STAT1_OFS, 8'h81);
    rd(fmc_pkg::STAT1_OFS, 8'h81);
    tmr <= 1'b1;
    cyc(3);
    rd(fmc_pkg::STAT1_OFS, 8'h89);
    cond <= 7'h00;
    tmr <= 1'b0;
    sec <= 8'h00;
    mode <= 1'b0;
    cyc(3);
    wr(fmc_pkg::STAT1_OFS, 8'hFF);
    rd(fmc_pkg::STAT1_OFS, 8'h09);
    rd(fmc_pkg::STAT1_OFS, 8'h00);
    $display("test status done");
    wr(fmc_pkg::IRQ_CLR_OFS, 8'h07);
    wr(fmc_pkg::IRQ_EN_OFS, 8'h02);
    cyc(3);
    `CHK("irq masked", 1'b0, irq)
    rd(fmc_pkg::IRQ_STAT_OFS, 8'h04);
    cond <= 7'h10;
    cyc(3);
    cond <= 7'h00;
    cyc(3);
    `CHK("irq raised", 1'b1, irq)
    rd(fmc_pkg::STAT1_OFS, 8'h10);
    cyc(2);
    wr(fmc_pkg::IRQ_CLR_OFS, 8'h02);
    cyc(3);
    `CHK("irq cleared", 1'b0, irq)
    wr(fmc_pkg::IRQ_EN_OFS, 8'h04);
    cyc(3);
    `CHK("irq ready", 1'b1, irq)
    rd(8'h60, 8'h00);
    $display("test interrupt done");
    wr(fmc_pkg::CFG_OFS, 8'h03);
    cyc(2);
    `CHK("cfg lock", 8'h07, cfg)
    wr(fmc_pkg::DUTY1_OFS, ~v[0]);
    wr(fmc_pkg::CFG_OFS, 8'hF8);
    cyc(2);
    `CHK("duty1 lock", v[0], duty1)
    `CHK("cfg locked", 8'h0F, cfg)
    wr(fmc_pkg::CFG_OFS, 8'h00);
    rd(fmc_pkg::CFG_OFS, 8'h07);
    rd(fmc_pkg::IRQ_STAT_OFS, 8'h05);
    cyc(1);
    rst_in <= 1'b1;
    cyc(4);
    rst_in <= 1'b0;
    rd(fmc_pkg::CFG_OFS, 8'h01);
    rd(fmc_pkg::DUTY1_OFS, 8'hFF);
    $display("test lock done");
    cyc(3);
    close_out();
  end
endmodule

// ==== fmc_flag_bit.sv ====
// One clear-on-read limit flag with its own assertions.
module fmc_flag_bit (
  input wire logic clk_in, // Clock.
  input wire logic rst_in, // Synchronous reset.
  input wire logic ce_in, // Clock enable.
  input wire logic cond_in, // Live limit condition.
  input wire logic rd_in, // Host read of the status register.
  output logic flag_out // Latched flag.
);
  // Every check here runs on the one clock and rests during reset.
  default clocking cb_flag @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  // A read only clears the flag once the condition is gone; set wins.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flag_out <= 1'b0;
    end else if (ce_in) begin
      if (cond_in) begin
        flag_out <= 1'b1;
      end else if (rd_in) begin
        flag_out <= 1'b0;
      end
    end
  end
  // A missed set hides a limit event; a missed clear repeats an old one.
  a_flag_sets: assert property (ce_in && cond_in |=> flag_out)
    else $error("flag did not set on condition");
  a_flag_read_keeps: assert property (
    ce_in && rd_in && cond_in |=> flag_out)
    else $error("flag cleared while condition present");
  a_flag_read_clears: assert property (
    ce_in && rd_in && !cond_in |=> !flag_out)
    else $error("flag not cleared by read");
  // Without a read or a condition the flag must not move at all.
  a_flag_holds: assert property (
    !rd_in && !cond_in |=> $stable(flag_out))
    else $error("flag changed without cause");
endmodule

// ==== fmc_host_model.sv ====
// Host model that issues one-cycle register reads and writes.
module fmc_host_model (
  output fmc_pkg::fmc_bus_s bus_out, // Request toward the register group.
  input wire logic clk_in // Bench clock.
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bus_out = '0;
  // One strobe cycle, then idle with inverted fields, so a design that
  // samples address or data late sees a wrong value, not a kind one.
  task automatic access(input logic [7:0] a, input logic [7:0] d,
                        input logic w);
    @(posedge clk_in);
    bus_out <= '{addr: a, wdata: d, wr: w, rd: ~w};
    @(posedge clk_in);
    bus_out <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask
endmodule

// ==== fmc_pkg.sv ====
// Constants and carrier types shared by the fan monitor register group.
// Summary of operation
// - Three duty ceilings, reset to full scale.
// - Lock makes lockable registers ignore writes.
// - Run bit selects programmed or default limits.
// - Run bit frozen once lock written.
// - Lock bit sets once until power cycle.
// - Ready bit set by device after power-up.
// - All-fans-max bit resets zero, never locked.
// - Core power report flag, lockable, informational.
// - Spin-up pulse skip holds drive for timeout.
// - Bus timeout select bit, lockable.
// - Supply scaling: one 5 V, zero 3.3 V.
// - Status bits 0-2 flag voltage limits.
// - Limit flags clear on read if condition gone.
// - Bit 3: 5 V limit or thermal timer.
// - Bits 4-6 flag temperature limits.
// - Bit 7 is OR of second status.
package fmc_pkg;
  localparam logic [7:0] DUTY1_OFS = 8'h38;
  localparam logic [7:0] DUTY2_OFS = 8'h39;
  localparam logic [7:0] DUTY3_OFS = 8'h3A;
  localparam logic [7:0] CFG_OFS = 8'h40;
  localparam logic [7:0] STAT1_OFS = 8'h41;
  localparam logic [7:0] IRQ_EN_OFS = 8'h50;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h51;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h52;
  localparam logic [7:0] DUTY_RST = 8'hFF;
  localparam logic [7:0] CFG_RST = 8'h01;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam int CFG_RUN = 0;
  localparam int CFG_LOCK = 1;
  localparam int CFG_RDY = 2;
  localparam int CFG_MAX = 3;
  localparam int CFG_VXI = 4;
  localparam int CFG_SKIP = 5;
  localparam int CFG_TMO = 6;
  localparam int CFG_VCC = 7;
  localparam int ST_SUM = 7;
  localparam int IRQ_LOCK = 0;
  localparam int IRQ_LIMIT = 1;
  localparam int IRQ_READY = 2;
  // Power-up settling time before the ready bit rises.
  localparam int PWRUP_NS = 1000;
  localparam int CLK_NS = 5;
  localparam int PWRUP_CYC = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fmc_bus_s;
  typedef struct packed {
    logic vcc_5v;
    logic bus_timeout;
    logic spinup_skip;
    logic core_report;
    logic all_max;
    logic ready;
    logic locked;
    logic run;
  } fmc_cfg_s;
endpackage

// ==== fmc_regs.sv ====
// Duty ceilings, main configuration and first status register group.
module fmc_regs (
  input wire logic clk_in, // 200 MHz clock.
  input wire logic rst_in, // Synchronous reset, active high.
  input wire logic ce_in, // Clock enable; low freezes all state.
  input wire fmc_pkg::fmc_bus_s bus_in, // Register bus request.
  output logic [7:0] rdata_out, // Read data, cycle after read strobe.
  input wire logic [2:0] volt_cond_in, // 2.5 V, core, supply out of limit.
  input wire logic volt5_cond_in, // 5 V out of limit.
  input wire logic thermal_limit_pin_timer_in, // Thermal timer limit exceeded.
  input wire logic thermal_limit_pin_pin_mode_in, // Shared pin is thermal-limit input.
  input wire logic [2:0] temp_cond_in, // Remote1, local, remote2 limits.
  input wire logic [7:0] second_status_in, // Second status register.
  output logic [7:0] duty1_out, // Duty ceiling, output 1.
  output logic [7:0] duty2_out, // Duty ceiling, output 2.
  output logic [7:0] duty3_out, // Duty ceiling, output 3.
  output fmc_pkg::fmc_cfg_s cfg_out, // Configuration bits.
  output logic irq_out // Level interrupt.
);
  logic [7:0] duty1_reg;
  logic [7:0] duty2_reg;
  logic [7:0] duty3_reg;
  logic [7:0] cfg_reg;
  logic [7:0] stat_reg;
  logic [2:0] irq_en_reg;
  logic [2:0] irq_st_reg;
  logic [2:0] irq_ev;
  logic [6:0] cond_vec;
  logic [6:0] flags;
  logic stat_rd;
  logic locked;
  // Counter width follows the settling count, so it cannot wrap early.
  localparam int PWR_W = $clog2(fmc_pkg::PWRUP_CYC + 1);
  localparam logic [PWR_W-1:0] PWR_END = PWR_W'(fmc_pkg::PWRUP_CYC);
  // Bits that stay live under lock: ready is owned by the device, and
  // all-fans-max stays reachable so a locked system can still cool hard.
  localparam logic [7:0] CFG_FREE = (8'h01 << fmc_pkg::CFG_RDY) |
    (8'h01 << fmc_pkg::CFG_MAX);
  logic [PWR_W-1:0] pwr_cnt_reg;
  logic pwr_done;
  logic [7:0] rdata_next;

  // All checks below run on the one clock and rest during reset, except a_reset_duty.
  default clocking cb_regs @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  // Write to the given address, accepted only while unlocked.
  function automatic logic wr_hit(input fmc_pkg::fmc_bus_s b,
                                  input logic [7:0] ofs,
                                  input logic lk);
    wr_hit = b.wr && b.addr == ofs && !lk;
  endfunction

  assign locked = cfg_reg[fmc_pkg::CFG_LOCK];
  assign stat_rd = bus_in.rd && bus_in.addr == fmc_pkg::STAT1_OFS;

  // Duty ceilings start at full scale and freeze once locked.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      duty1_reg <= fmc_pkg::DUTY_RST;
      duty2_reg <= fmc_pkg::DUTY_RST;
      duty3_reg <= fmc_pkg::DUTY_RST;
    end else if (ce_in) begin
      if (wr_hit(bus_in, fmc_pkg::DUTY1_OFS, locked)) begin
        duty1_reg <= bus_in.wdata;
      end
      if (wr_hit(bus_in, fmc_pkg::DUTY2_OFS, locked)) begin
        duty2_reg <= bus_in.wdata;
      end
      if (wr_hit(bus_in, fmc_pkg::DUTY3_OFS, locked)) begin
        duty3_reg <= bus_in.wdata;
      end
    end
  end

  // Power-up counter; the ready bit only rises when it expires.
  assign pwr_done = pwr_cnt_reg == PWR_END;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pwr_cnt_reg <= '0;
    end else if (ce_in && !pwr_done) begin
      pwr_cnt_reg <= pwr_cnt_reg + 1'b1;
    end
  end

  // Configuration: lockable bits hold once lock is set; all-fans-max never
  // locks. Reset stands in for a power cycle, the only way to unlock.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cfg_reg <= fmc_pkg::CFG_RST;
    end else if (ce_in) begin
      if (pwr_done) begin
        cfg_reg[fmc_pkg::CFG_RDY] <= 1'b1;
      end
      if (bus_in.wr && bus_in.addr == fmc_pkg::CFG_OFS) begin
        cfg_reg[fmc_pkg::CFG_MAX] <= bus_in.wdata[fmc_pkg::CFG_MAX];
        if (!locked) begin
          cfg_reg[fmc_pkg::CFG_RUN] <= bus_in.wdata[fmc_pkg::CFG_RUN];
          cfg_reg[fmc_pkg::CFG_LOCK] <= bus_in.wdata[fmc_pkg::CFG_LOCK];
          cfg_reg[fmc_pkg::CFG_VXI] <= bus_in.wdata[fmc_pkg::CFG_VXI];
          cfg_reg[fmc_pkg::CFG_SKIP] <= bus_in.wdata[fmc_pkg::CFG_SKIP];
          cfg_reg[fmc_pkg::CFG_TMO] <= bus_in.wdata[fmc_pkg::CFG_TMO];
          cfg_reg[fmc_pkg::CFG_VCC] <= bus_in.wdata[fmc_pkg::CFG_VCC];
        end
      end
    end
  end

  // Bit 3 picks its source from how the shared pin is configured.
  assign cond_vec = {temp_cond_in,
                     thermal_limit_pin_pin_mode_in ? thermal_limit_pin_timer_in : volt5_cond_in,
                     volt_cond_in};

  // One flag cell per limit bit.
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_flag
      fmc_flag_bit u_flag (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .cond_in(cond_vec[gi]),
        .rd_in(stat_rd),
        .flag_out(flags[gi])
      );
    end
  endgenerate

  // Summary bit follows the second status register with no latency, so a
  // read never reports an event there that is already gone. Host writes
  // have no path into it.
  assign stat_reg = {|second_status_in, flags};

  // Interrupt events: lock taken, any first status bit (limit flags or summary), ready reached.
  assign irq_ev[fmc_pkg::IRQ_LOCK] = locked;
  assign irq_ev[fmc_pkg::IRQ_LIMIT] = |stat_reg;
  assign irq_ev[fmc_pkg::IRQ_READY] = cfg_reg[fmc_pkg::CFG_RDY];

  // Sticky interrupt status; an event in the clearing cycle wins.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_st_reg <= fmc_pkg::IRQ_RST;
      irq_en_reg <= fmc_pkg::IRQ_RST;
    end else if (ce_in) begin
      if (bus_in.wr && bus_in.addr == fmc_pkg::IRQ_EN_OFS) begin
        irq_en_reg <= bus_in.wdata[2:0];
      end
      if (bus_in.wr && bus_in.addr == fmc_pkg::IRQ_CLR_OFS) begin
        irq_st_reg <= (irq_st_reg & ~bus_in.wdata[2:0]) | irq_ev;
      end else begin
        irq_st_reg <= irq_st_reg | irq_ev;
      end
    end
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    rdata_next = 8'h00;
    unique case (bus_in.addr)
      fmc_pkg::DUTY1_OFS: rdata_next = duty1_reg;
      fmc_pkg::DUTY2_OFS: rdata_next = duty2_reg;
      fmc_pkg::DUTY3_OFS: rdata_next = duty3_reg;
      fmc_pkg::CFG_OFS: rdata_next = cfg_reg;
      fmc_pkg::STAT1_OFS: rdata_next = stat_reg;
      fmc_pkg::IRQ_EN_OFS: rdata_next = {5'h00, irq_en_reg};
      fmc_pkg::IRQ_STAT_OFS: rdata_next = {5'h00, irq_st_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  // Output registers; read data stand only in the cycle after the strobe.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
      duty1_out <= fmc_pkg::DUTY_RST;
      duty2_out <= fmc_pkg::DUTY_RST;
      duty3_out <= fmc_pkg::DUTY_RST;
      cfg_out <= fmc_pkg::CFG_RST;
      irq_out <= 1'b0;
    end else if (ce_in) begin
      rdata_out <= bus_in.rd ? rdata_next : 8'h00;
      duty1_out <= duty1_reg;
      duty2_out <= duty2_reg;
      duty3_out <= duty3_reg;
      // The run bit is passed out for the limit engines to pick programmed
      // or default limits; programmed values are never touched here.
      cfg_out <= cfg_reg;
      irq_out <= |(irq_st_reg & irq_en_reg);
    end
  end

  // Lock guards every duty ceiling; a slip would let rogue code raise them.
  a_duty_lock_hold: assert property (
    locked |=> $stable(duty1_reg) && $stable(duty2_reg) && $stable(duty3_reg))
    else $error("duty ceiling changed while locked");
  // Only ready and all-fans-max may move in a locked configuration.
  a_cfg_lock_hold: assert property (
    locked |=> $stable(cfg_reg & ~CFG_FREE))
    else $error("lockable configuration bit changed while locked");
  a_lock_sticky: assert property (locked |=> locked)
    else $error("lock bit cleared");
  a_run_frozen: assert property (
    locked |=> $stable(cfg_reg[fmc_pkg::CFG_RUN]))
    else $error("run bit changed after lock");
  a_max_writable: assert property (
    ce_in && bus_in.wr && bus_in.addr == fmc_pkg::CFG_OFS
    |=> cfg_reg[fmc_pkg::CFG_MAX] == $past(bus_in.wdata[fmc_pkg::CFG_MAX]))
    else $error("all-fans-max write lost");
  // Ready is owned by the device: never early and never missed.
  a_ready_timing: assert property (
    cfg_reg[fmc_pkg::CFG_RDY] |-> pwr_done)
    else $error("ready before power-up done");
  a_ready_rises: assert property (
    ce_in && pwr_done |=> cfg_reg[fmc_pkg::CFG_RDY])
    else $error("ready bit missed after power-up");
  // The summary bit that the host reads matches the second status register.
  a_summary_read: assert property (
    ce_in && stat_rd
    |=> rdata_out[fmc_pkg::ST_SUM] == |$past(second_status_in))
    else $error("summary bit wrong");
  a_read_one_cycle: assert property (
    ce_in && !bus_in.rd |=> rdata_out == 8'h00)
    else $error("read data outside read slot");
  // Reset must be checked while it is active, so this one is never disabled.
  a_reset_duty: assert property (disable iff (1'b0)
    rst_in |=> duty2_reg == fmc_pkg::DUTY_RST)
    else $error("duty ceiling reset wrong");
  // The limit engines see the run bit one cycle after it is written.
  a_cfg_out_copy: assert property (
    ce_in |=> cfg_out == $past(cfg_reg))
    else $error("configuration output lags wrongly");
  // An event in the cycle of a clear must leave its status bit set.
  a_irq_event_wins: assert property (
    ce_in && locked |=> irq_st_reg[fmc_pkg::IRQ_LOCK])
    else $error("interrupt event lost");
  a_irq_level: assert property (
    ce_in |=> irq_out == |($past(irq_st_reg) & $past(irq_en_reg)))
    else $error("interrupt level wrong");
  c_lock_set: cover property (@(posedge clk_in) !locked ##1 locked);
  c_flag_read: cover property (@(posedge clk_in) stat_rd && stat_reg != 8'h00);
  c_irq: cover property (@(posedge clk_in) irq_out);
  c_ce_write: cover property (@(posedge clk_in) !ce_in && bus_in.wr);
endmodule
